// file: core/trigger_sequencer.sv
// Programmable trigger sequencer for an embedded logic analyzer.
// Assumes probes are synchronous to aclk and an AXI4-Lite master.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////
// One probe comparator
module cmp_unit #(parameter int W = 8) (
  // Probe now and one sample ago
  input  wire logic [W-1:0]       sample,
  input  wire logic [W-1:0]       prev,
  // Constant, care mask, relation
  input  wire logic [tsm_pkg::DW-1:0] cfg,
  output logic                    hit
);
  import tsm_pkg::*;
  logic [W-1:0] a;
  logic [W-1:0] b;
  logic         one_bit;

  // Care mask zero means don't-care on both sides
  assign a = sample & cfg[PC_CARE_LSB +: W];
  assign b = cfg[PC_VAL_LSB +: W] & cfg[PC_CARE_LSB +: W];
  assign one_bit = (W == 1);

  // Relation select; edge codes only live on 1-bit probes
  always_comb begin
    unique case (cfg[PC_OP_LSB +: PC_OP_W])
      OP_EQ:   hit = (a == b);
      OP_NE:   hit = (a != b);
      OP_GT:   hit = (a > b);
      OP_LT:   hit = (a < b);
      OP_GE:   hit = (a >= b);
      OP_LE:   hit = (a <= b);
      OP_RISE: hit = one_bit && !prev[0] && sample[0];
      OP_BOTH: hit = one_bit && (prev[0] != sample[0]);
      OP_NONE: hit = one_bit && (prev[0] == sample[0]);
      default: hit = 1'b0;
    endcase
  end
endmodule : cmp_unit

////////////////////////////////////////////////////////////////////
// Behaviour
// - Four status markers, indices 0 to 3, show program progress.
// - Actions set or clear any marker; it holds until changed again.
// - Each probe comparison owns one comparator on its probe port.
// - Comparators per probe port fixed at build time, 1 to 4.
// - Probe relations: equal, not equal, greater, less, ge, le.
// - Constant is probe-wide; each bit zero, one or don't-care.
// - One-bit probes also detect rise, any edge, or no edge.
// - Each tally owns exactly one counter comparator.
// - Counter comparator supports only equal and not equal.
// - Every tally and its constant are 16 bits wide.
// - Probe results in a condition reduce by one AND or OR.
// - Probe result joins one counter result by AND or OR.
// - Two- and three-way branches; first true path wins, else last.
// - Each path runs actions then jumps or fires the trigger.
// - Program holds up to 16 states.
// - Actions reset a tally to zero or increment it by one.
module trigger_sequencer (
  // Clock, reset, enable
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  // Probes from the user design
  input  wire logic [tsm_pkg::PROBE0_W-1:0] probe0,
  input  wire logic [tsm_pkg::PROBE1_W-1:0] probe1,
  // AXI4-Lite write
  input  wire logic [tsm_pkg::AW-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [tsm_pkg::DW-1:0] wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // AXI4-Lite read
  input  wire logic [tsm_pkg::AW-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [tsm_pkg::DW-1:0]     rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // Results
  output logic                       capture_trigger,
  output logic                       triggered,
  output logic [tsm_pkg::NUM_MARKERS-1:0] status_marker,
  output logic                       irq
);
  import tsm_pkg::*;

  run_mode_e              mode;
  logic [STATE_W-1:0]     cur;
  logic [TALLY_W-1:0]     event_tally [NUM_TALLIES];
  logic [DW-1:0]          prog [PROG_WORDS];
  logic [DW-1:0]          cmp_cfg [NUM_CMP];
  logic [DW-1:0]          cnt_cfg [NUM_TALLIES];
  logic [PROBE0_W-1:0]    prev0;
  logic [PROBE1_W-1:0]    prev1;
  logic [NUM_CMP-1:0]     cmp_hit;
  logic [NUM_TALLIES-1:0] cnt_hit;
  logic [IRQ_W-1:0]       int_stat;
  logic [IRQ_W-1:0]       int_en;
  logic                   aw_held;
  logic                   w_held;
  logic [AW-1:0]          wa;
  logic [DW-1:0]          wd;
  logic [3:0]             ws;
  logic                   wr_fire;
  logic                   wr_ok;
  logic [AW-1:0]          ra;
  logic [DW-1:0]          rd_word;
  logic                   rd_ok;
  logic [DW-1:0]          hdr;
  logic                   cond_a;
  logic                   cond_b;
  logic [DW-1:0]          sel_path;
  logic                   step;
  logic                   arm_req;
  logic                   halt_req;
  logic [IRQ_W-1:0]       events;

  ////////////////////////////////////////////////////////////////
  // Comparators: one shared pool, any condition may select any of them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev0 <= '0;
      prev1 <= '0;
    end else if (ce) begin
      prev0 <= probe0;
      prev1 <= probe1;
    end
  end

  for (genvar g = 0; g < CMP_PER_PORT; g++) begin : g_cmp
    cmp_unit #(.W(PROBE0_W)) u_p0 (
      .sample (probe0),
      .prev   (prev0),
      .cfg    (cmp_cfg[g]),
      .hit    (cmp_hit[g])
    );
    cmp_unit #(.W(PROBE1_W)) u_p1 (
      .sample (probe1),
      .prev   (prev1),
      .cfg    (cmp_cfg[g + CMP_PER_PORT]),
      .hit    (cmp_hit[g + CMP_PER_PORT])
    );
  end

  // Exactly one comparator per tally, equal or not equal only
  for (genvar t = 0; t < NUM_TALLIES; t++) begin : g_cnt
    assign cnt_hit[t] = cnt_cfg[t][CC_NE_BIT] ?
      (event_tally[t] != cnt_cfg[t][TALLY_W-1:0]) :
      (event_tally[t] == cnt_cfg[t][TALLY_W-1:0]);
  end

  ////////////////////////////////////////////////////////////////
  // Condition: probes under one operator, then one tally joined
  function automatic logic cond_eval(input logic [DW-1:0] c,
                                     input logic [NUM_CMP-1:0] ph,
                                     input logic [NUM_TALLIES-1:0] th);
    logic [NUM_CMP-1:0] sel;
    logic pv;
    logic cv;
    logic pu;
    logic cu;
    sel = c[C_SEL_LSB +: NUM_CMP];
    pu = |sel;
    cu = c[C_CUSE_BIT];
    pv = c[C_POP_BIT] ? |(ph & sel) : &(ph | ~sel);
    cv = th[c[C_CSEL_LSB +: 2]];
    if (pu && cu) cond_eval = c[C_JOIN_BIT] ? (pv | cv) : (pv & cv);
    else if (pu) cond_eval = pv;
    else cond_eval = cu & cv;
  endfunction : cond_eval

  // Current state's words; first true condition picks the path
  assign hdr = prog[{cur, W_HDR}];
  assign cond_a = cond_eval(prog[{cur, W_CONDA}], cmp_hit, cnt_hit);
  assign cond_b = cond_eval(prog[{cur, W_CONDB}], cmp_hit, cnt_hit);
  always_comb begin
    unique case (hdr[HDR_WAYS_LSB +: 2])
      2'h0: sel_path = prog[{cur, W_PATH0}];
      2'h1: sel_path = cond_a ? prog[{cur, W_PATH0}] :
                       prog[{cur, W_PATH1}];
      default: sel_path = cond_a ? prog[{cur, W_PATH0}] :
                          cond_b ? prog[{cur, W_PATH1}] :
                          prog[{cur, W_PATH2}];
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer: one step per enabled cycle, frozen once hit
  assign step = ce && (mode == MODE_ARMED) && !arm_req && !halt_req;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MODE_IDLE;
      cur <= '0;
      status_marker <= '0;
      capture_trigger <= 1'b0;
    end else if (ce) begin
      capture_trigger <= step && sel_path[P_TRG_BIT];
      if (arm_req) begin
        mode <= MODE_ARMED;
        cur <= '0;
        status_marker <= '0;
      end else if (halt_req) begin
        mode <= MODE_IDLE;
      end else if (step) begin
        cur <= sel_path[P_NXT_LSB +: STATE_W];
        // Set wins when a path both sets and clears a marker
        status_marker <= (status_marker & ~sel_path[P_CLR_LSB +: NUM_MARKERS])
                       | sel_path[P_SET_LSB +: NUM_MARKERS];
        if (sel_path[P_TRG_BIT]) mode <= MODE_HIT;
      end
    end
  end
  assign triggered = (mode == MODE_HIT);

  // Tallies; reset beats increment, wrap at 16 bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_TALLIES; i++) event_tally[i] <= '0;
    end else if (ce) begin
      for (int i = 0; i < NUM_TALLIES; i++) begin
        if (arm_req) event_tally[i] <= '0;
        else if (step && sel_path[P_RST_LSB + i]) event_tally[i] <= '0;
        else if (step && sel_path[P_INC_LSB + i])
          event_tally[i] <= event_tally[i] + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Interrupts: sticky events, set beats a same-cycle clear
  assign events[IRQ_TRIG_BIT] = step && sel_path[P_TRG_BIT];
  assign events[IRQ_MOVE_BIT] = step && (sel_path[P_NXT_LSB +: STATE_W] != cur);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat <= '0;
    end else if (ce) begin
      if (wr_fire && wa == A_INT_CLR)
        int_stat <= (int_stat & ~wd[IRQ_W-1:0]) | events;
      else
        int_stat <= int_stat | events;
    end
  end
  assign irq = |(int_stat & int_en);

  ////////////////////////////////////////////////////////////////
  // AXI write: address and data in either order, one at a time
  assign awready = ce && !aw_held && !bvalid;
  assign wready = ce && !w_held && !bvalid;
  assign wr_fire = aw_held && w_held && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wa <= '0;
      wd <= '0;
      ws <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wa <= {awaddr[AW-1:2], 2'h0};
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wd <= wdata;
        ws <= wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Writable map; status and tallies refuse writes
  always_comb begin
    wr_ok = 1'b1;
    if (wa[AW-1:9] == A_PROG[AW-1:9]) wr_ok = 1'b1;
    else if (wa[AW-1:4] == A_CNT_CFG[AW-1:4]) wr_ok = 1'b1;
    else if (wa[AW-1:5] == A_CMP_CFG[AW-1:5]) wr_ok = 1'b1;
    else wr_ok = (wa == A_CTRL) || (wa == A_INT_EN) || (wa == A_INT_CLR);
  end
  assign arm_req = wr_fire && (wa == A_CTRL) && ws[0] && wd[CTRL_ARM_BIT];
  assign halt_req = wr_fire && (wa == A_CTRL) && ws[0] && wd[CTRL_HALT_BIT];

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                          input logic [DW-1:0] nw,
                                          input logic [3:0] st);
    for (int i = 0; i < 4; i++) if (st[i]) old[8*i +: 8] = nw[8*i +: 8];
    return old;
  endfunction : merge

  // Config storage; reloading mid-run changes the live program
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_en <= '0;
      for (int i = 0; i < PROG_WORDS; i++) prog[i] <= RST_WORD;
      for (int i = 0; i < NUM_CMP; i++) cmp_cfg[i] <= RST_WORD;
      for (int i = 0; i < NUM_TALLIES; i++) cnt_cfg[i] <= RST_WORD;
    end else if (ce && wr_fire) begin
      if (wa == A_INT_EN && ws[0]) int_en <= wd[IRQ_W-1:0];
      if (wa[AW-1:9] == A_PROG[AW-1:9])
        prog[wa[8:2]] <= merge(prog[wa[8:2]], wd, ws);
      if (wa[AW-1:5] == A_CMP_CFG[AW-1:5])
        cmp_cfg[wa[4:2]] <= merge(cmp_cfg[wa[4:2]], wd, ws);
      if (wa[AW-1:4] == A_CNT_CFG[AW-1:4])
        cnt_cfg[wa[3:2]] <= merge(cnt_cfg[wa[3:2]], wd, ws);
    end
  end

  ////////////////////////////////////////////////////////////////
  // AXI read: one word, answered the cycle after the address
  assign arready = ce && !rvalid;
  assign ra = {araddr[AW-1:2], 2'h0};
  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    if (ra[AW-1:9] == A_PROG[AW-1:9]) rd_word = prog[ra[8:2]];
    else if (ra[AW-1:4] == A_TALLY[AW-1:4]) rd_word = {16'h0000, event_tally[ra[3:2]]};
    else if (ra[AW-1:4] == A_CNT_CFG[AW-1:4]) rd_word = cnt_cfg[ra[3:2]];
    else if (ra[AW-1:5] == A_CMP_CFG[AW-1:5]) rd_word = cmp_cfg[ra[4:2]];
    else if (ra == A_STATUS) begin
      rd_word[ST_STATE_LSB +: STATE_W] = cur;
      rd_word[ST_MARK_LSB +: NUM_MARKERS] = status_marker;
      rd_word[ST_ARMED_BIT] = (mode == MODE_ARMED);
      rd_word[ST_HIT_BIT] = (mode == MODE_HIT);
    end
    else if (ra == A_INT_STAT) rd_word[IRQ_W-1:0] = int_stat;
    else if (ra == A_INT_EN) rd_word[IRQ_W-1:0] = int_en;
    else rd_ok = (ra == A_CTRL) || (ra == A_INT_CLR);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  marker_set_a: assert property (step && sel_path[P_SET_LSB] |=> status_marker[0])
    else $error("marker 0 not set by path");
  hit_hold_a: assert property (triggered && !arm_req && !halt_req |=>
    $stable(status_marker) && $stable(cur) && $stable(event_tally[0]))
    else $error("state moved after trigger");
  trig_fire_a: assert property (step && sel_path[P_TRG_BIT] |=> capture_trigger && triggered)
    else $error("trigger path did not fire");
  next_state_a: assert property (step |=> cur == $past(sel_path[P_NXT_LSB +: STATE_W]))
    else $error("next state not taken");
  tally_clear_a: assert property (step && sel_path[P_RST_LSB + 1] |=> event_tally[1] == 16'h0000)
    else $error("tally 1 not reset");
  tally_inc_a: assert property (step && !sel_path[P_RST_LSB] && sel_path[P_INC_LSB] |=>
    event_tally[0] == $past(event_tally[0]) + 16'h0001)
    else $error("tally 0 not incremented");
  cnt_ne_a: assert property (cnt_cfg[2][CC_NE_BIT] |->
    cnt_hit[2] == (event_tally[2] != cnt_cfg[2][15:0]))
    else $error("counter not-equal wrong");
  else_path_a: assert property (hdr[1:0] == 2'h2 && !cond_a && !cond_b |->
    sel_path == prog[{cur, W_PATH2}])
    else $error("three-way else not taken");

  trig_seen_c: cover property (capture_trigger);
  else_way_c: cover property (step && hdr[1:0] == 2'h2 && !cond_a && !cond_b);
  rise_c: cover property (cmp_cfg[CMP_PER_PORT][19:16] == OP_RISE && cmp_hit[CMP_PER_PORT]);
  wr_done_c: cover property (bvalid && bready);
endmodule : trigger_sequencer
`default_nettype wire

// file: core/tsm_pkg.sv
// Constants, field layouts and types for the trigger sequencer.
// Assumes a 32-bit AXI4-Lite register bus with 12 address bits.
package tsm_pkg;
  // Bus shape
  localparam int AW = 12;
  localparam int DW = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Probe ports and comparators (1 to 4 per port)
  localparam int PROBE0_W = 8;
  localparam int PROBE1_W = 1;
  localparam int CMP_PER_PORT = 4;
  localparam int NUM_CMP = 2 * CMP_PER_PORT;
  // Markers, tallies, program size
  localparam int NUM_MARKERS = 4;
  localparam int NUM_TALLIES = 4;
  localparam int TALLY_W = 16;
  localparam int STATE_W = 4;
  localparam int PROG_WORDS = 128;
  // Register byte addresses
  localparam logic [AW-1:0] A_CTRL = 12'h000;
  localparam logic [AW-1:0] A_STATUS = 12'h004;
  localparam logic [AW-1:0] A_INT_STAT = 12'h008;
  localparam logic [AW-1:0] A_INT_EN = 12'h00C;
  localparam logic [AW-1:0] A_INT_CLR = 12'h010;
  localparam logic [AW-1:0] A_TALLY = 12'h020;
  localparam logic [AW-1:0] A_CNT_CFG = 12'h030;
  localparam logic [AW-1:0] A_CMP_CFG = 12'h040;
  localparam logic [AW-1:0] A_PROG = 12'h200;
  // Control and status fields
  localparam int CTRL_ARM_BIT = 0;
  localparam int CTRL_HALT_BIT = 1;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_MARK_LSB = 4;
  localparam int ST_ARMED_BIT = 8;
  localparam int ST_HIT_BIT = 9;
  localparam int IRQ_W = 2;
  localparam int IRQ_TRIG_BIT = 0;
  localparam int IRQ_MOVE_BIT = 1;
  // Probe comparator config word
  localparam int PC_VAL_LSB = 0;
  localparam int PC_CARE_LSB = 8;
  localparam int PC_OP_LSB = 16;
  localparam int PC_OP_W = 4;
  localparam logic [3:0] OP_EQ = 4'h0;
  localparam logic [3:0] OP_NE = 4'h1;
  localparam logic [3:0] OP_GT = 4'h2;
  localparam logic [3:0] OP_LT = 4'h3;
  localparam logic [3:0] OP_GE = 4'h4;
  localparam logic [3:0] OP_LE = 4'h5;
  localparam logic [3:0] OP_RISE = 4'h6;
  localparam logic [3:0] OP_BOTH = 4'h7;
  localparam logic [3:0] OP_NONE = 4'h8;
  // Counter comparator config word
  localparam int CC_NE_BIT = 16;
  // Program words per state
  localparam logic [2:0] W_HDR = 3'h0;
  localparam logic [2:0] W_CONDA = 3'h1;
  localparam logic [2:0] W_CONDB = 3'h2;
  localparam logic [2:0] W_PATH0 = 3'h3;
  localparam logic [2:0] W_PATH1 = 3'h4;
  localparam logic [2:0] W_PATH2 = 3'h5;
  localparam int HDR_WAYS_LSB = 0;
  // Condition word
  localparam int C_SEL_LSB = 0;
  localparam int C_POP_BIT = 8;
  localparam int C_CSEL_LSB = 9;
  localparam int C_CUSE_BIT = 11;
  localparam int C_JOIN_BIT = 12;
  // Path word
  localparam int P_SET_LSB = 0;
  localparam int P_CLR_LSB = 4;
  localparam int P_INC_LSB = 8;
  localparam int P_RST_LSB = 12;
  localparam int P_NXT_LSB = 16;
  localparam int P_TRG_BIT = 20;
  // Reset value of every config word
  localparam logic [DW-1:0] RST_WORD = 32'h00000000;

  typedef enum logic [1:0] {MODE_IDLE, MODE_ARMED, MODE_HIT} run_mode_e;
endpackage : tsm_pkg

// file: verification/probe_source.sv
// Stand-in for the user design whose signals the probe ports watch.
// Assumes one clock shared with the sequencer and a synchronous reset.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////
module probe_source (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Observed signals
  output logic [7:0]      probe0,
  output logic [0:0]      probe1
);
  // Free-running count, so every 8-bit value recurs every 256 cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      probe0 <= 8'h00;
    end else begin
      probe0 <= probe0 + 8'h01;
    end
  end

  // Low bit rises exactly when the count moves from even to odd
  assign probe1 = probe0[0];
endmodule : probe_source

`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench: programs the sequencer over AXI4-Lite and
// follows it to the trigger. Assumes probe_source drives the probes.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////
module testbench;
  import tsm_pkg::*;

  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  logic [7:0]            probe0;
  logic [0:0]            probe1;
  logic [AW-1:0]         awaddr = '0, araddr = '0;
  logic [DW-1:0]         wdata = '0, rdata;
  logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                  arvalid = 1'b0, rready = 1'b0;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [1:0]            bresp, rresp, resp;
  logic                  capture_trigger, triggered, irq;
  logic [3:0]            status_marker;
  logic [31:0]           v;
  int                    bad_count = 0, samples_checked = 0, cyc = 0, n;

  // 40 MHz clock
  always #12.5 aclk = ~aclk;

  probe_source u_src (.aclk(aclk), .aresetn(aresetn), .probe0(probe0), .probe1(probe1));

  trigger_sequencer u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .probe0(probe0), .probe1(probe1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .capture_trigger(capture_trigger),
    .triggered(triggered), .status_marker(status_marker), .irq(irq));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Write one word; address and data offered together, response awaited
  task automatic axw(input logic [AW-1:0] a, input logic [DW-1:0] d, output logic [1:0] r);
    bit aw, w, got;
    aw = 1; w = 1; got = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (!aw && !w && bvalid === 1'b1) begin
        got = 1; r = bresp; bready <= 1'b0;
      end
      if (aw && awready === 1'b1) begin
        aw = 0; awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 0; wvalid <= 1'b0;
      end
    end
  endtask : axw

  // Read one word
  task automatic axr(input logic [AW-1:0] a, output logic [DW-1:0] d, output logic [1:0] r);
    bit ar, got;
    ar = 1; got = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (!ar && rvalid === 1'b1) begin
        got = 1; d = rdata; r = rresp; rready <= 1'b0;
      end
      if (ar && arready === 1'b1) begin
        ar = 0; arvalid <= 1'b0;
      end
    end
  endtask : axr

  // Verdict, reached from the main sequence or the hang guard
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // Hang guard: the whole run needs well under 3000 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  // Program: state 0 (three-way, empty cond B so the else path idles) waits for
  // probe0 == 05 with a rise on probe1, sets marker 0 and counts it;
  // state 1 (two-way) clears marker 0, sets marker 2 and fires once tally 0 equals 1.
  // Tally 2 gets a not-equal comparator that no condition uses.
  logic [AW-1:0] pa [12] = '{12'h040, 12'h050, 12'h030, 12'h200, 12'h204, 12'h20C,
                             12'h210, 12'h220, 12'h224, 12'h22C, 12'h230, 12'h038};
  logic [DW-1:0] pd [12] = '{32'h0000FF05, 32'h00060100, 32'h00000001, 32'h00000002,
                             32'h00000011, 32'h00010101, 32'h00000000, 32'h00000001,
                             32'h00001800, 32'h00100014, 32'h00010000, 32'h00010005};

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset state and refused accesses
    axr(A_STATUS, v, resp); chk("status after reset", 32'h00000000, v);
    axr(12'h7FC, v, resp); chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axw(A_STATUS, 32'h000000FF, resp); chk("status write resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    for (int i = 0; i < 12; i++) begin
      axw(pa[i], pd[i], resp);
    end
    axw(A_CTRL, 32'h00000001, resp);
    // Wait for the trigger pulse, then confirm it lasts one cycle;
    // looked at mid-cycle, clear of the edge that launches it
    n = 0;
    while (capture_trigger !== 1'b1 && n < 600) begin
      @(negedge aclk); n++;
    end
    chk("pulse seen", 32'h1, {31'h0, capture_trigger});
    @(negedge aclk);
    chk("pulse width", 32'h0, {31'h0, capture_trigger});
    chk("triggered", 32'h1, {31'h0, triggered});
    chk("markers", 32'h4, {28'h0, status_marker});
    axr(A_STATUS, v, resp); chk("status at hit", 32'h00000240, v);
    axr(A_TALLY, v, resp); chk("tally 0", 32'h00000001, v);
    repeat (10) @(posedge aclk);
    axr(A_STATUS, v, resp); chk("status held", 32'h00000240, v);
    axr(A_TALLY, v, resp); chk("tally held", 32'h00000001, v);
    // Interrupt: pending, masked, enabled, cleared
    axr(A_INT_STAT, v, resp); chk("int status", 32'h00000003, v);
    chk("irq masked", 32'h0, {31'h0, irq});
    axw(A_INT_EN, 32'h00000001, resp);
    chk("irq enabled", 32'h1, {31'h0, irq});
    axw(A_INT_CLR, 32'h00000001, resp);
    chk("irq cleared", 32'h0, {31'h0, irq});
    axr(A_INT_STAT, v, resp); chk("int status left", 32'h00000002, v);
    // Halt leaves the hit mode; rearming clears markers and tallies
    axw(A_CTRL, 32'h00000002, resp);
    chk("halted", 32'h0, {31'h0, triggered});
    axw(A_CTRL, 32'h00000001, resp);
    chk("markers rearmed", 32'h0, {28'h0, status_marker});
    axr(A_TALLY, v, resp); chk("tally rearmed", 32'h00000000, v);
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
